// File: tb_top.sv
// Self-checking bench of the under power factor stage.
// Assumes a short program cycle of CYC clocks so delays stay brief.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import upf_pkg::*;
;
	localparam int CYC = 8;
	logic               clk_sys = 1'b0;
	logic               rst = 1'b1;
	logic [PF_W-1:0]    pf_req = 7'h63;
	logic               blk_req = 1'b0;
	logic [GRP_W-1:0]   active_group = 3'h0;
	logic               allow_node_mode = 1'b0;
	logic               allow_stage_forcing = 1'b0;
	logic [7:0]         avs_address = 8'h00;
	logic               avs_read = 1'b0;
	logic               avs_write = 1'b0;
	logic [31:0]        avs_writedata = 32'h0;
	logic [PF_W-1:0]    three_phase_power_factor;
	logic               block_in;
	logic [31:0]        avs_readdata;
	logic               avs_waitrequest;
	logic               start_out, trip_out, alarm_start_out, alarm_out, blocked_out;
	upf_cond_t          condition;
	logic [NSRC-1:0]    event_on, event_off;
	logic [STAMP_W-1:0] event_stamp;
	int                 err_total = 0, checks_done = 0;

	always #50 clk_sys = ~clk_sys;

	upf_pf_source upf_pf_source_inst (.clk_sys(clk_sys), .rst(rst), .pf_req(pf_req),
		.blk_req(blk_req), .pf_out(three_phase_power_factor), .blk_out(block_in));
	upf_stage #(.CYCLE_CLKS(CYC)) upf_stage_inst (.clk_sys(clk_sys), .rst(rst),
		.three_phase_power_factor(three_phase_power_factor), .block_in(block_in),
		.active_group(active_group), .allow_node_mode(allow_node_mode),
		.allow_stage_forcing(allow_stage_forcing), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.start_out(start_out), .trip_out(trip_out), .alarm_start_out(alarm_start_out),
		.alarm_out(alarm_out), .blocked_out(blocked_out), .condition(condition),
		.event_on(event_on), .event_off(event_off), .event_stamp(event_stamp));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Request held until waitrequest is sampled low at a rising edge
	task bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask

	task bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask

	task ticks(input int n);
		repeat (n * CYC) @(posedge clk_sys);
	endtask

	task end_of_test;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Reset values, an unmapped read, an out-of-range threshold refused
	task t_regs;
		logic [7:0]  a [7] = '{OFF_CTRL, OFF_TRIP_DLY, OFF_ALARM_DLY, OFF_REL_DLY, OFF_EV_MASK,
			OFF_GROUP, 8'hfc};
		logic [31:0] e [7] = '{32'h0, 32'h14, 32'h14, 32'h0, 32'h3ff, 32'h5a50, 32'h0};
		logic [31:0] d;
		for (int i = 0; i < 7; i++)
		begin
			bus_rd(a[i], d);
			chk(d, e[i]);
		end
		bus_wr(OFF_GROUP, 32'h5a04);
		bus_rd(OFF_GROUP, d);
		chk(d, 32'h5a50);
		$display("test regs done");
	endtask

	// Trip after the full delay, ratios, 103 percent release
	task t_trip;
		int          n = 0;
		logic [31:0] d;
		bus_wr(OFF_CTRL, 32'h8);
		bus_wr(OFF_TRIP_DLY, 32'h3);
		pf_req <= 7'h4f;
		while (start_out !== 1'b1) @(posedge clk_sys);
		while (trip_out !== 1'b1)
		begin
			@(posedge clk_sys);
			n++;
		end
		chk(n, 2 * CYC);
		chk(alarm_start_out, 1'b0);
		bus_rd(OFF_RATIO, d);
		chk(d, 32'h0057_0062);
		bus_rd(OFF_CNT + 8'h08, d);
		chk(d, 32'h1);
		pf_req <= 7'h52;
		ticks(4);
		chk(trip_out, 1'b1);
		pf_req <= 7'h53;
		ticks(3);
		chk({start_out, trip_out}, 2'b00);
		$display("test trip done");
	endtask

	// Alarm stage alone between the two thresholds
	task t_alarm;
		bus_wr(OFF_CTRL, 32'h0);
		bus_wr(OFF_TRIP_DLY, 32'h14);
		bus_wr(OFF_ALARM_DLY, 32'h2);
		pf_req <= 7'h55;
		ticks(4);
		chk({alarm_start_out, alarm_out, start_out}, 3'b110);
		pf_req <= 7'h63;
		ticks(3);
		chk(alarm_out, 1'b0);
		$display("test alarm done");
	endtask

	// Blocking arrives while start is active
	task t_block;
		bus_wr(OFF_CTRL, 32'h8);
		pf_req <= 7'h4f;
		while (start_out !== 1'b1) @(posedge clk_sys);
		blk_req <= 1'b1;
		ticks(3);
		chk({start_out, blocked_out, trip_out}, 3'b010);
		pf_req <= 7'h63;
		blk_req <= 1'b0;
		ticks(3);
		$display("test block done");
	endtask

	// Thresholds follow the group, mode does not
	task t_group;
		logic [31:0] d;
		bus_wr(OFF_GROUP + 8'h04, 32'h3230);
		active_group <= 3'h1;
		pf_req <= 7'h4f;
		ticks(3);
		chk(start_out, 1'b0);
		bus_rd(OFF_STATUS, d);
		chk(d[11:6], 6'h08);
		active_group <= 3'h0;
		ticks(3);
		chk(start_out, 1'b1);
		pf_req <= 7'h63;
		ticks(3);
		$display("test group done");
	endtask

	// Every operating mode, then permission withdrawn
	task t_modes;
		logic [4:0]  es = 5'b00101;
		logic [4:0]  eb = 5'b01010;
		logic [31:0] d;
		allow_node_mode <= 1'b1;
		for (int m = 0; m < 5; m++)
		begin
			bus_wr(OFF_CTRL, 32'h8 | 32'(m));
			pf_req <= 7'h4f;
			ticks(3);
			chk({start_out, blocked_out}, {es[m], eb[m]});
			pf_req <= 7'h63;
			ticks(3);
		end
		allow_node_mode <= 1'b0;
		bus_rd(OFF_STATUS, d);
		chk(d[8:6], 3'h0);
		$display("test modes done");
	endtask

	// Every forced status, then forcing withdrawn
	task t_force;
		allow_stage_forcing <= 1'b1;
		for (int f = 0; f < 6; f++)
		begin
			bus_wr(OFF_CTRL, 32'(f) << 4);
			repeat (3) @(posedge clk_sys);
			chk(condition, 32'h1 << f);
		end
		allow_stage_forcing <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk(condition, 32'h1);
		$display("test force done");
	endtask

	initial
	begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		t_regs();
		t_trip();
		t_alarm();
		t_block();
		t_group();
		t_modes();
		t_force();
		end_of_test();
	end

	// Whole run needs about 650 clocks
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		end_of_test();
	end
endmodule
`default_nettype wire

// File: upf_pf_source.sv
// Measurement side model: power factor and blocking matrix output.
// Assumes requests from the bench on clk_sys; values are held levels.
`timescale 1ns/1ps
`default_nettype none
module upf_pf_source
	import upf_pkg::*;
(
	input wire logic            clk_sys,
	input wire logic            rst,
	input wire logic [PF_W-1:0] pf_req,
	input wire logic            blk_req,
	output logic     [PF_W-1:0] pf_out,
	output logic                blk_out
);
	// Healthy unity-near value after reset; blocking passes in one clock,
	// far ahead of any operate delay, so it always lands in time
	always_ff @(posedge clk_sys)
	begin
		pf_out  <= rst ? 7'h63 : pf_req;
		blk_out <= rst ? 1'b0 : blk_req;
	end
endmodule
`default_nettype wire

// File: upf_pkg.sv
// Constants, encodings and register map of the under power factor stage.
// Assumes a 10 MHz system clock and a 5 ms protection program cycle.
`default_nettype none
package upf_pkg;

	// Clock and program cycle timing
	localparam int unsigned CLK_HZ         = 10_000_000;
	localparam int unsigned CYCLE_MS       = 5;
	localparam int unsigned CYCLE_CLKS_DEF = CLK_HZ / 1000 * CYCLE_MS;
	localparam int          DIV_W          = 16;

	// Power factor in hundredths, thresholds and reset ratio
	localparam int          PF_W          = 7;
	localparam logic [6:0]  THR_MIN       = 7'h05;
	localparam logic [6:0]  THR_MAX       = 7'h63;
	localparam logic [6:0]  TRIP_THR_RST  = 7'h50;
	localparam logic [6:0]  ALARM_THR_RST = 7'h5a;
	localparam logic [13:0] PCT_SCALE     = 14'h0064;
	localparam logic [13:0] RESET_PCT     = 14'h0067;

	// Widths of setting groups, delays, ratios and records
	localparam int GROUPS  = 8;
	localparam int GRP_W   = 3;
	localparam int DLY_W   = 19;
	localparam int REM_W   = 20;
	localparam int RATIO_W = 12;
	localparam int STAMP_W = 32;
	localparam int CNT_W   = 16;
	localparam int REC_N   = 12;
	localparam int REC_W   = 4;
	localparam int NSRC    = 5;

	// Power factor history taps, in program cycles
	localparam int PRE_TRIG_MS  = 20;
	localparam int PRE_FAULT_MS = 200;
	localparam int LAG_TRIG     = PRE_TRIG_MS / CYCLE_MS;
	localparam int LAG_FAULT    = PRE_FAULT_MS / CYCLE_MS;
	localparam int HIST_N       = LAG_FAULT;

	// Delay reset values, in program cycles
	localparam logic [DLY_W-1:0] DLY_TRIP_RST  = 19'h00014;
	localparam logic [DLY_W-1:0] DLY_ALARM_RST = 19'h00014;
	localparam logic [DLY_W-1:0] DLY_REL_RST   = 19'h00000;

	// Indication bit positions
	localparam int EV_BLOCK  = 0;
	localparam int EV_START  = 1;
	localparam int EV_TRIP   = 2;
	localparam int EV_ASTART = 3;
	localparam int EV_ALARM  = 4;

	// Record event codes
	localparam logic [2:0] REC_EV_START   = 3'h0;
	localparam logic [2:0] REC_EV_TRIP    = 3'h1;
	localparam logic [2:0] REC_EV_BLOCKED = 3'h2;

	typedef enum logic [2:0] {
		MODE_ON = 3'h0, MODE_BLOCKED = 3'h1, MODE_TEST = 3'h2,
		MODE_TEST_BLOCKED = 3'h3, MODE_OFF = 3'h4
	} upf_mode_t;

	typedef enum logic [2:0] {
		FORCE_NORMAL = 3'h0, FORCE_START = 3'h1, FORCE_TRIP = 3'h2,
		FORCE_BLOCKED = 3'h3, FORCE_ASTART = 3'h4, FORCE_ALARM = 3'h5
	} upf_force_t;

	typedef enum logic [5:0] {
		COND_NORMAL = 6'h01, COND_START = 6'h02, COND_TRIP = 6'h04,
		COND_BLOCKED = 6'h08, COND_ASTART = 6'h10, COND_ALARM = 6'h20
	} upf_cond_t;

	// Control, event mask and group register fields
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_AVAIL_BIT = 3;
	localparam int CTRL_FORCE_LSB = 4;
	localparam int FIELD3_W       = 3;
	localparam int MASK_OFF_LSB   = 5;
	localparam int GRP_ALARM_LSB  = 8;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_TRIP_DLY  = 8'h04;
	localparam logic [7:0] OFF_ALARM_DLY = 8'h08;
	localparam logic [7:0] OFF_REL_DLY   = 8'h0c;
	localparam logic [7:0] OFF_EV_MASK   = 8'h10;
	localparam logic [7:0] OFF_CNT_CLR   = 8'h14;
	localparam logic [7:0] OFF_REC_SEL   = 8'h18;
	localparam logic [7:0] OFF_STATUS    = 8'h20;
	localparam logic [7:0] OFF_TRIP_REM  = 8'h24;
	localparam logic [7:0] OFF_ALARM_REM = 8'h28;
	localparam logic [7:0] OFF_EXP_TRIP  = 8'h2c;
	localparam logic [7:0] OFF_EXP_ALARM = 8'h30;
	localparam logic [7:0] OFF_RATIO     = 8'h34;
	localparam logic [7:0] OFF_CNT       = 8'h40;
	localparam logic [7:0] OFF_CNT_LAST  = 8'h50;
	localparam logic [7:0] OFF_REC_PF    = 8'h60;
	localparam logic [7:0] OFF_REC_REM   = 8'h64;
	localparam logic [7:0] OFF_REC_STAMP = 8'h68;
	localparam logic [7:0] OFF_GROUP     = 8'h80;
	localparam logic [7:0] OFF_GROUP_END = 8'h9c;

endpackage
`default_nettype wire

// File: upf_stage.sv
// Under power factor protection stage with its Avalon-MM register slave.
// Assumes power factor and blocking come from logic on clk_sys, in hundredths.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Trip when measured power factor below minimum
// - Release only at 103 percent of setting
// - Trip threshold 0.05 to 0.99, default 0.80
// - Alarm threshold 0.05 to 0.99, default 0.90
// - Trips only or trips plus alarms selection
// - Five operating modes, gated by global permission
// - Force status, gated by global forcing enable
// - Mode and forcing independent of setting group
// - Thresholds follow active group, live changeable
// - Blocking input sampled each program cycle
// - Unblocked pick-up starts operate delay timing
// - Blocked pick-up shows blocked, stops processing
// - Blocking clears start, runs release timing
// - Definite time operate and release delays
// - Exactly one of six conditions shown
// - Signed remaining trip time in cycles
// - Remaining alarm time and expected alarm delay
// - Measured to trip setting ratio shown
// - Measured to alarm setting ratio shown
// - ON and OFF events, individually selectable
// - Resettable counters for five events
// - Last twelve operation records kept
module upf_stage
	import upf_pkg::*;
#(
	parameter int unsigned CYCLE_CLKS = CYCLE_CLKS_DEF
)(
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic [PF_W-1:0]   three_phase_power_factor,
	input  wire logic              block_in,
	input  wire logic [GRP_W-1:0]  active_group,
	input  wire logic              allow_node_mode,
	input  wire logic              allow_stage_forcing,
	input  wire logic [7:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	output logic                   start_out,
	output logic                   trip_out,
	output logic                   alarm_start_out,
	output logic                   alarm_out,
	output logic                   blocked_out,
	output upf_cond_t              condition,
	output logic      [NSRC-1:0]   event_on,
	output logic      [NSRC-1:0]   event_off,
	output logic      [STAMP_W-1:0] event_stamp
);

	// Pick-up test with hysteresis: once held, release needs the reset ratio
	function automatic logic picked(input logic [PF_W-1:0] pf, input logic [PF_W-1:0] thr,
		input logic held);
		if (held)
			picked = ({7'h00, pf} * PCT_SCALE) < ({7'h00, thr} * RESET_PCT);
		else
			picked = pf < thr;
	endfunction

	// Measured over setting in hundredths; saturates on a zero setting
	function automatic logic [RATIO_W-1:0] ratio(input logic [PF_W-1:0] pf,
		input logic [PF_W-1:0] thr);
		logic [13:0] num;
		num = {7'h00, pf} * PCT_SCALE;
		if (thr == 7'h00)
			ratio = '1;
		else
			ratio = RATIO_W'(num / {7'h00, thr});
	endfunction

	// Indication pattern that a forced status stands for
	function automatic logic [NSRC-1:0] force_vec(input upf_force_t f);
		case (f)
			FORCE_START:   force_vec = 5'h02;
			FORCE_TRIP:    force_vec = 5'h06;
			FORCE_BLOCKED: force_vec = 5'h01;
			FORCE_ASTART:  force_vec = 5'h08;
			FORCE_ALARM:   force_vec = 5'h18;
			default:       force_vec = 5'h00;
		endcase
	endfunction

	// Single condition by severity
	function automatic upf_cond_t cond_of(input logic [NSRC-1:0] ind);
		if (ind[EV_TRIP])
			cond_of = COND_TRIP;
		else if (ind[EV_ALARM])
			cond_of = COND_ALARM;
		else if (ind[EV_START])
			cond_of = COND_START;
		else if (ind[EV_ASTART])
			cond_of = COND_ASTART;
		else if (ind[EV_BLOCK])
			cond_of = COND_BLOCKED;
		else
			cond_of = COND_NORMAL;
	endfunction

	logic [DIV_W-1:0]   div_cnt;
	logic               ack;
	upf_mode_t          mode_q;
	upf_force_t         force_q;
	logic               trips_only;
	logic [DLY_W-1:0]   trip_dly;
	logic [DLY_W-1:0]   alarm_dly;
	logic [DLY_W-1:0]   rel_dly;
	logic [2*NSRC-1:0]  ev_mask;
	logic [REC_W-1:0]   rec_sel;
	logic [PF_W-1:0]    thr_trip [GROUPS];
	logic [PF_W-1:0]    thr_alarm [GROUPS];
	logic [1:0]         pick_q;
	logic [1:0]         go_q;
	logic [1:0]         op_q;
	logic               blk_q;
	logic [DLY_W-1:0]   cnt_q [2];
	logic [DLY_W-1:0]   rel_q [2];
	logic [NSRC-1:0]    ind_prev;
	logic [STAMP_W-1:0] stamp;
	logic [CNT_W-1:0]   ev_cnt [NSRC];
	logic [PF_W-1:0]    hist [HIST_N];
	logic [31:0]        rec_pf [REC_N];
	logic [REM_W-1:0]   rec_rem [REC_N];
	logic [STAMP_W-1:0] rec_stamp [REC_N];
	logic [REC_W-1:0]   rec_ptr;
	logic [REC_W-1:0]   rec_cnt;
	logic [31:0]        rd_word;

	// Program cycle enable; every comparison and timer steps on it
	wire tick = (div_cnt == DIV_W'(CYCLE_CLKS - 1));

	always_ff @(posedge clk_sys)
	begin
		if (rst || tick)
			div_cnt <= '0;
		else
			div_cnt <= div_cnt + 1'b1;
	end

	// Bus handshake: every access answers after exactly one wait cycle
	wire req    = avs_read | avs_write;
	wire wr_go  = avs_write & ack;
	assign avs_waitrequest = req & ~ack;

	wire wr_ctrl   = wr_go && (avs_address == OFF_CTRL);
	wire wr_tdly   = wr_go && (avs_address == OFF_TRIP_DLY);
	wire wr_adly   = wr_go && (avs_address == OFF_ALARM_DLY);
	wire wr_rdly   = wr_go && (avs_address == OFF_REL_DLY);
	wire wr_mask   = wr_go && (avs_address == OFF_EV_MASK);
	wire wr_clr    = wr_go && (avs_address == OFF_CNT_CLR);
	wire wr_sel    = wr_go && (avs_address == OFF_REC_SEL);
	wire in_group  = (avs_address >= OFF_GROUP) && (avs_address <= OFF_GROUP_END)
		&& (avs_address[1:0] == 2'h0);
	wire wr_grp    = wr_go && in_group;
	wire [GRP_W-1:0] grp_idx = avs_address[4:2];
	wire in_cnt    = (avs_address >= OFF_CNT) && (avs_address <= OFF_CNT_LAST)
		&& (avs_address[1:0] == 2'h0);

	// Written fields and their acceptance
	wire [FIELD3_W-1:0] wd_mode  = avs_writedata[CTRL_MODE_LSB +: FIELD3_W];
	wire [FIELD3_W-1:0] wd_force = avs_writedata[CTRL_FORCE_LSB +: FIELD3_W];
	wire [PF_W-1:0] wd_thr_t = avs_writedata[0 +: PF_W];
	wire [PF_W-1:0] wd_thr_a = avs_writedata[GRP_ALARM_LSB +: PF_W];
	wire mode_ok  = allow_node_mode && (wd_mode <= MODE_OFF);
	wire force_ok = allow_stage_forcing && (wd_force <= FORCE_ALARM);
	wire thr_ok   = (wd_thr_t >= THR_MIN) && (wd_thr_t <= THR_MAX)
		&& (wd_thr_a >= THR_MIN) && (wd_thr_a <= THR_MAX);

	// Acknowledge and read data capture
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ack <= 1'b0;
			avs_readdata <= '0;
		end
		else
		begin
			ack <= req & ~ack;
			if (avs_read && !ack)
				avs_readdata <= rd_word;
		end
	end

	// Static settings; not part of any setting group
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			mode_q <= MODE_ON;
			force_q <= FORCE_NORMAL;
			trips_only <= 1'b0;
			trip_dly <= DLY_TRIP_RST;
			alarm_dly <= DLY_ALARM_RST;
			rel_dly <= DLY_REL_RST;
			ev_mask <= '1;
			rec_sel <= '0;
		end
		else
		begin
			if (wr_ctrl)
			begin
				if (mode_ok)
					mode_q <= upf_mode_t'(wd_mode);
				if (force_ok)
					force_q <= upf_force_t'(wd_force);
				trips_only <= avs_writedata[CTRL_AVAIL_BIT];
			end
			if (wr_tdly)
				trip_dly <= avs_writedata[DLY_W-1:0];
			if (wr_adly)
				alarm_dly <= avs_writedata[DLY_W-1:0];
			if (wr_rdly)
				rel_dly <= avs_writedata[DLY_W-1:0];
			if (wr_mask)
				ev_mask <= avs_writedata[2*NSRC-1:0];
			if (wr_sel && (avs_writedata[REC_W-1:0] < REC_W'(REC_N)))
				rec_sel <= avs_writedata[REC_W-1:0];
		end
	end

	// Per-group thresholds; writable while the stage runs
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			for (int g = 0; g < GROUPS; g++)
			begin
				thr_trip[g] <= TRIP_THR_RST;
				thr_alarm[g] <= ALARM_THR_RST;
			end
		end
		else if (wr_grp && thr_ok)
		begin
			thr_trip[grp_idx] <= wd_thr_t;
			thr_alarm[grp_idx] <= wd_thr_a;
		end
	end

	// Effective mode and forcing; a withdrawn permission falls back to defaults
	wire upf_mode_t  mode_eff  = allow_node_mode ? mode_q : MODE_ON;
	wire upf_force_t force_eff = allow_stage_forcing ? force_q : FORCE_NORMAL;
	wire running = (mode_eff != MODE_OFF);
	wire test_md = (mode_eff == MODE_TEST) || (mode_eff == MODE_TEST_BLOCKED);
	wire blk     = block_in || (mode_eff == MODE_BLOCKED) || (mode_eff == MODE_TEST_BLOCKED);

	// Stage 0 is trip, stage 1 is alarm
	wire [PF_W-1:0]  pf = three_phase_power_factor;
	wire [PF_W-1:0]  thr_sel [2];
	wire [DLY_W-1:0] dly_sel [2];
	wire [1:0]       pick_n;
	wire [1:0]       go_n;
	wire [1:0]       reach;
	wire [DLY_W-1:0] cnt_inc [2];
	wire [DLY_W-1:0] rel_inc [2];
	assign thr_sel[0] = thr_trip[active_group];
	assign thr_sel[1] = thr_alarm[active_group];
	assign dly_sel[0] = trip_dly;
	assign dly_sel[1] = alarm_dly;

	for (genvar s = 0; s < 2; s++)
	begin : g_stage
		wire en = running && ((s == 0) || !trips_only);
		assign pick_n[s] = en && picked(pf, thr_sel[s], pick_q[s]);
		assign go_n[s] = pick_n[s] && !blk;
		assign cnt_inc[s] = (&cnt_q[s]) ? cnt_q[s] : cnt_q[s] + 1'b1;
		assign rel_inc[s] = (&rel_q[s]) ? rel_q[s] : rel_q[s] + 1'b1;
		assign reach[s] = cnt_inc[s] >= dly_sel[s];
	end

	// Definite time timers; block and loss of pick-up share the release path
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pick_q <= '0;
			go_q <= '0;
			op_q <= '0;
			blk_q <= 1'b0;
			for (int s = 0; s < 2; s++)
			begin
				cnt_q[s] <= '0;
				rel_q[s] <= '0;
			end
		end
		else if (tick)
		begin
			pick_q <= pick_n;
			go_q <= go_n;
			op_q <= go_n & reach;
			blk_q <= running && blk && (|pick_n);
			for (int s = 0; s < 2; s++)
			begin
				if (!running)
				begin
					cnt_q[s] <= '0;
					rel_q[s] <= '0;
				end
				else if (go_n[s])
				begin
					cnt_q[s] <= cnt_inc[s];
					rel_q[s] <= '0;
				end
				else if (cnt_q[s] != '0)
				begin
					if (rel_inc[s] >= rel_dly)
					begin
						cnt_q[s] <= '0;
						rel_q[s] <= '0;
					end
					else
						rel_q[s] <= rel_inc[s];
				end
			end
		end
	end

	// Live indications: remaining times and ratios
	wire [REM_W-1:0] trip_rem = REM_W'({1'b0, trip_dly}) - REM_W'({1'b0, cnt_q[0]});
	wire [DLY_W-1:0] alarm_rem = (cnt_q[1] >= alarm_dly) ? '0 : alarm_dly - cnt_q[1];
	wire [RATIO_W-1:0] trip_ratio  = ratio(pf, thr_sel[0]);
	wire [RATIO_W-1:0] alarm_ratio = ratio(pf, thr_sel[1]);

	// Indication vector, forced or measured
	wire [NSRC-1:0] ind_raw = {op_q[1], go_q[1], op_q[0], go_q[0], blk_q};
	wire [NSRC-1:0] ind = (force_eff != FORCE_NORMAL) ? force_vec(force_eff) : ind_raw;
	wire [NSRC-1:0] io_mask = test_md ? ~((NSRC'(1) << EV_TRIP) | (NSRC'(1) << EV_ALARM)) : '1;
	wire [NSRC-1:0] rise = ind & ~ind_prev;
	wire [NSRC-1:0] fall = ~ind & ind_prev;

	// Outputs and events; test mode keeps trip and alarm off the I/O
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ind_prev <= '0;
			{alarm_out, alarm_start_out, trip_out, start_out, blocked_out} <= '0;
			condition <= COND_NORMAL;
			event_on <= '0;
			event_off <= '0;
			event_stamp <= '0;
		end
		else
		begin
			ind_prev <= ind;
			{alarm_out, alarm_start_out, trip_out, start_out, blocked_out} <= ind & io_mask;
			condition <= cond_of(ind);
			event_on <= rise & ev_mask[NSRC-1:0];
			event_off <= fall & ev_mask[MASK_OFF_LSB +: NSRC];
			event_stamp <= stamp;
		end
	end

	// Cycle stamp and event counters; a count on the clear cycle survives
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			stamp <= '0;
			for (int i = 0; i < NSRC; i++)
				ev_cnt[i] <= '0;
		end
		else
		begin
			if (tick)
				stamp <= stamp + 1'b1;
			for (int i = 0; i < NSRC; i++)
			begin
				if (wr_clr && avs_writedata[i])
					ev_cnt[i] <= rise[i] ? CNT_W'(1) : '0;
				else if (rise[i] && !(&ev_cnt[i]))
					ev_cnt[i] <= ev_cnt[i] + 1'b1;
			end
		end
	end

	// Operation records on start, trip or blocked ON; oldest overwritten
	wire rec_go = rise[EV_TRIP] | rise[EV_START] | rise[EV_BLOCK];
	wire [2:0] rec_ev = rise[EV_TRIP] ? REC_EV_TRIP : (rise[EV_START] ? REC_EV_START
		: REC_EV_BLOCKED);
	wire [REC_W-1:0] next_ptr = (rec_ptr == REC_W'(REC_N - 1)) ? '0 : rec_ptr + 1'b1;
	wire [REC_W:0] rd_sum = {1'b0, rec_ptr} + (REC_W + 1)'(REC_N - 1) - {1'b0, rec_sel};
	wire [REC_W:0] rd_fix = (rd_sum >= (REC_W + 1)'(REC_N)) ? rd_sum - (REC_W + 1)'(REC_N)
		: rd_sum;
	wire [REC_W-1:0] rd_idx = rd_fix[REC_W-1:0];

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			rec_ptr <= '0;
			rec_cnt <= '0;
			for (int i = 0; i < HIST_N; i++)
				hist[i] <= '0;
			for (int r = 0; r < REC_N; r++)
			begin
				rec_pf[r] <= '0;
				rec_rem[r] <= '0;
				rec_stamp[r] <= '0;
			end
		end
		else
		begin
			if (tick)
			begin
				hist[0] <= pf;
				for (int i = 1; i < HIST_N; i++)
					hist[i] <= hist[i-1];
			end
			if (rec_go)
			begin
				rec_pf[rec_ptr] <= {1'b0, rec_ev, 1'b0, active_group, 1'b0, hist[LAG_FAULT-1],
					1'b0, pf, 1'b0, hist[LAG_TRIG-1]};
				rec_rem[rec_ptr] <= trip_rem;
				rec_stamp[rec_ptr] <= stamp;
				rec_ptr <= next_ptr;
				if (rec_cnt != REC_W'(REC_N))
					rec_cnt <= rec_cnt + 1'b1;
			end
		end
	end

	// Read decode; unmapped or unaligned addresses read as zero
	always_comb
	begin
		rd_word = '0;
		if (avs_address == OFF_CTRL)
			rd_word = {25'h0, force_q, trips_only, mode_q};
		else if (avs_address == OFF_TRIP_DLY)
			rd_word = {13'h0, trip_dly};
		else if (avs_address == OFF_ALARM_DLY)
			rd_word = {13'h0, alarm_dly};
		else if (avs_address == OFF_REL_DLY)
			rd_word = {13'h0, rel_dly};
		else if (avs_address == OFF_EV_MASK)
			rd_word = {22'h0, ev_mask};
		else if (avs_address == OFF_REC_SEL)
			rd_word = {28'h0, rec_sel};
		else if (avs_address == OFF_STATUS)
			rd_word = {16'h0, rec_cnt, active_group, mode_eff, condition};
		else if (avs_address == OFF_TRIP_REM)
			rd_word = {{12{trip_rem[REM_W-1]}}, trip_rem};
		else if (avs_address == OFF_ALARM_REM)
			rd_word = {13'h0, alarm_rem};
		else if (avs_address == OFF_EXP_TRIP)
			rd_word = {13'h0, trip_dly};
		else if (avs_address == OFF_EXP_ALARM)
			rd_word = {13'h0, alarm_dly};
		else if (avs_address == OFF_RATIO)
			rd_word = {4'h0, alarm_ratio, 4'h0, trip_ratio};
		else if (in_cnt)
			rd_word = {16'h0, ev_cnt[avs_address[4:2]]};
		else if (avs_address == OFF_REC_PF)
			rd_word = rec_pf[rd_idx];
		else if (avs_address == OFF_REC_REM)
			rd_word = {{12{rec_rem[rd_idx][REM_W-1]}}, rec_rem[rd_idx]};
		else if (avs_address == OFF_REC_STAMP)
			rd_word = rec_stamp[rd_idx];
		else if (in_group)
			rd_word = {17'h0, thr_alarm[grp_idx], 1'b0, thr_trip[grp_idx]};
	end

endmodule
`default_nettype wire

// File: upf_stage_checker.sv
// Concurrent checks on the ports of the under power factor stage.
// Assumes it is bound to upf_stage and shares its one clock and reset.
`timescale 1ns/1ps
`default_nettype none
module upf_stage_checker
	import upf_pkg::*;
#(
	parameter int unsigned CYCLE_CLKS = CYCLE_CLKS_DEF
)(
	input wire logic               clk_sys,
	input wire logic               rst,
	input wire logic [PF_W-1:0]    three_phase_power_factor,
	input wire logic               block_in,
	input wire logic [GRP_W-1:0]   active_group,
	input wire logic               allow_node_mode,
	input wire logic               allow_stage_forcing,
	input wire logic [7:0]         avs_address,
	input wire logic               avs_read,
	input wire logic               avs_write,
	input wire logic [31:0]        avs_writedata,
	input wire logic [31:0]        avs_readdata,
	input wire logic               avs_waitrequest,
	input wire logic               start_out,
	input wire logic               trip_out,
	input wire logic               alarm_start_out,
	input wire logic               alarm_out,
	input wire logic               blocked_out,
	input wire upf_cond_t          condition,
	input wire logic [NSRC-1:0]    event_on,
	input wire logic [NSRC-1:0]    event_off,
	input wire logic [STAMP_W-1:0] event_stamp
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	// Bus request seen while the slave still stalls
	sequence seq_req_waiting;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence seq_start_rise;
		$rose(start_out);
	endsequence

	// Bus: at most one wait cycle, no stall when idle, read data held
	AST_WAIT_ONE: assert property (seq_req_waiting ##1 (avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait state longer than one cycle");
	AST_IDLE_NO_WAIT: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest high without request");
	AST_READ_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data changed without a read");
	// Condition display against the indications
	AST_COND_ONEHOT: assert property ($onehot(condition))
		else $error("condition not one-hot");
	AST_TRIP_COND: assert property (trip_out |-> condition == COND_TRIP)
		else $error("trip without trip condition");
	AST_START_COND: assert property (start_out && condition != COND_TRIP && condition != COND_ALARM |-> condition == COND_START)
		else $error("start without start condition");
	AST_BLOCK_EXCL: assert property (blocked_out |-> !start_out && !trip_out)
		else $error("blocked together with start or trip");
	// Events follow the indication edges in the same cycle
	AST_START_EVENT: assert property (seq_start_rise |-> event_on[EV_START])
		else $error("start rise without event");
	AST_TRIP_OFF_EVENT: assert property ($fell(trip_out) |-> event_off[EV_TRIP])
		else $error("trip fall without event");
	AST_BLOCK_EVENT: assert property ($rose(blocked_out) |-> event_on[EV_BLOCK])
		else $error("block rise without event");
endmodule

bind upf_stage upf_stage_checker #(.CYCLE_CLKS(CYCLE_CLKS)) upf_stage_checker_inst (
	.clk_sys(clk_sys), .rst(rst), .three_phase_power_factor(three_phase_power_factor),
	.block_in(block_in), .active_group(active_group), .allow_node_mode(allow_node_mode),
	.allow_stage_forcing(allow_stage_forcing), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .start_out(start_out), .trip_out(trip_out),
	.alarm_start_out(alarm_start_out), .alarm_out(alarm_out), .blocked_out(blocked_out),
	.condition(condition), .event_on(event_on), .event_off(event_off),
	.event_stamp(event_stamp)
);
`default_nettype wire
